// File: mlt_avg_div.sv
`timescale 1ns/1ps
module mlt_avg_div
  import mlt_pkg::*;
#(
  parameter int NW = 20,
  parameter int DW = 16,
  parameter int CW = $clog2(NW + 1)
) (
  input  wire logic          CLK,
  input  wire logic          ARST_N,
  input  wire logic          START,
  input  wire logic [NW-1:0] NUM,
  input  wire logic [DW-1:0] DEN,
  output logic               DONE,
  output logic      [NW-1:0] QUO
);

  logic [DW:0]   rem_r;
  logic [CW-1:0] cnt_r;
  logic          busy_r;

  // Restoring divide, one quotient bit a cycle; divisor must hold still
  wire logic [DW:0] rem_sh = {rem_r[DW-1:0], QUO[NW-1]};
  wire logic        take   = rem_sh >= {1'b0, DEN};

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rem_r  <= '0;
      QUO    <= '0;
      cnt_r  <= '0;
      busy_r <= 1'b0;
      DONE   <= 1'b0;
    end else begin
      DONE <= 1'b0;
      if (START) begin
        rem_r  <= '0;
        QUO    <= NUM;
        cnt_r  <= CW'(NW);
        busy_r <= 1'b1;
      end else if (busy_r) begin
        rem_r <= take ? (rem_sh - {1'b0, DEN}) : rem_sh;
        QUO   <= {QUO[NW-2:0], take};
        cnt_r <= cnt_r - CW'(1);
        if (cnt_r == CW'(1)) begin
          busy_r <= 1'b0;
          DONE   <= 1'b1;
        end
      end
    end
  end

endmodule : mlt_avg_div

// File: mlt_mem.sv
`timescale 1ns/1ps
module mlt_mem
  import mlt_pkg::*;
#(
  parameter int W  = 8,
  parameter int D  = 256,
  parameter int AW = $clog2(D)
) (
  input  wire logic          CLK,
  input  wire logic          ARST_N,
  input  wire logic          WE,
  input  wire logic [AW-1:0] WA,
  input  wire logic [W-1:0]  WD,
  input  wire logic [AW-1:0] RA,
  output logic      [W-1:0]  RD
);

  logic [W-1:0] mem_r [D];

  always_ff @(posedge CLK) begin
    if (WE) begin
      mem_r[WA] <= WD;
    end
  end

  // Bypass so a word written now reads back at once
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      RD <= '0;
    end else begin
      RD <= (WE && (WA == RA)) ? WD : mem_r[RA];
    end
  end

endmodule : mlt_mem

// File: mlt_peer.sv
`timescale 1ns/1ps
// ****
// Peer MAC answering test packets
// ****
module mlt_peer
  import mlt_pkg::*;
(
  input  wire logic         CLK,
  input  wire logic         ARST_N,
  input  wire mlt_rf_hdr_t  RF_TX_HDR,
  input  wire logic         RF_TX_LAST,
  output logic              RF_TX_DONE,
  output mlt_tx_stat_t      RF_TX_STAT
);
  logic [1:0] cnt_r;
  logic       alt_r;
  // Late answer, so the tester must really wait
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      cnt_r      <= 2'h0;
      alt_r      <= 1'b0;
      RF_TX_DONE <= 1'b0;
      RF_TX_STAT <= '0;
    end else begin
      RF_TX_DONE <= (cnt_r == 2'h1);
      if (RF_TX_LAST && RF_TX_HDR.cluster == CL_TEST_PKT) begin
        cnt_r <= 2'h3;
      end else if (cnt_r != 2'h0) begin
        cnt_r <= cnt_r - 2'h1;
      end
      if (cnt_r == 2'h1) begin
        RF_TX_STAT <= '{1'b1, 4'h2, alt_r ? 8'h54 : 8'h50};
        alt_r      <= !alt_r;
      end
    end
  end
endmodule : mlt_peer

// File: mlt_pkg.sv
package mlt_pkg;

  // ****************************************
  // Frame types, clusters and endpoints
  // ****************************************
  localparam logic [7:0]  FT_AGG_UPDATE = 8'h8e;
  localparam logic [7:0]  FT_EXPL_RX    = 8'h91;
  localparam logic [15:0] CL_LOOPBACK   = 16'h0012;
  localparam logic [15:0] CL_TEST_REQ   = 16'h0014;
  localparam logic [15:0] CL_TEST_RES   = 16'h0094;
  localparam logic [15:0] CL_TEST_PKT   = 16'h0015;
  localparam logic [7:0]  EP_DATA       = 8'he8;
  localparam logic [7:0]  EP_TEST       = 8'he6;
  localparam logic [63:0] AGG_KEEP      = 64'h0000_0000_0000_fffe;
  localparam logic [63:0] BCAST_ADDR    = 64'h0000_0000_0000_ffff;
  localparam logic [15:0] MAX_ITER      = 16'h0fa0;
  localparam logic [15:0] LEN_TREQ      = 16'h000c;
  localparam logic [15:0] LEN_TRES      = 16'h0015;
  localparam logic [15:0] LEN_AGG       = 16'h0008;
  localparam logic [15:0] LEN_AGG_FRM   = 16'h0011;
  localparam logic [15:0] LEN_RES_FRM   = 16'h0016;
  localparam logic [7:0]  RES_OK        = 8'h00;
  localparam logic [7:0]  RES_BADPARAM  = 8'h03;

  // ****************************************
  // Register map and reset values
  // ****************************************
  localparam logic [7:0]  REG_CTRL      = 8'h00;
  localparam logic [7:0]  REG_DEST_HI   = 8'h04;
  localparam logic [7:0]  REG_DEST_LO   = 8'h08;
  localparam logic [7:0]  REG_SER_HI    = 8'h0c;
  localparam logic [7:0]  REG_SER_LO    = 8'h10;
  localparam logic [7:0]  REG_AGG_HI    = 8'h14;
  localparam logic [7:0]  REG_AGG_LO    = 8'h18;
  localparam logic [7:0]  REG_RETRY     = 8'h1c;
  localparam logic [7:0]  REG_STATUS    = 8'h20;
  localparam logic [7:0]  REG_ROUTE_IDX = 8'h24;
  localparam logic [7:0]  REG_ROUTE_HI  = 8'h28;
  localparam logic [7:0]  REG_ROUTE_LO  = 8'h2c;
  localparam int          CTRL_API_BIT  = 0;
  localparam int          CTRL_CL_LSB   = 8;
  localparam logic [63:0] RST_DEST      = 64'h0000_0000_0000_ffff;
  localparam logic [15:0] RST_CLUSTER   = 16'h0011;
  localparam logic [7:0]  RST_RETRY     = 8'h0a;

  // ****************************************
  // Emitter byte sources
  // ****************************************
  localparam logic [1:0]  SRC_BUF       = 2'h0;
  localparam logic [1:0]  SRC_ECHO      = 2'h1;
  localparam logic [1:0]  SRC_PAT       = 2'h2;

  // ****************************************
  // Types
  // ****************************************
  typedef struct packed {
    logic        agg;
    logic [63:0] addr;
    logic [15:0] cluster;
    logic [7:0]  src_ep;
    logic [7:0]  dst_ep;
  } mlt_rf_hdr_t;

  typedef struct packed {
    logic       ack;
    logic [3:0] retries;
    logic [7:0] rssi;
  } mlt_tx_stat_t;

  typedef enum logic [4:0] {
    S_IDLE = 5'h01,
    S_RX   = 5'h02,
    S_EMIT = 5'h04,
    S_WAIT = 5'h08,
    S_DIV  = 5'h10
  } mlt_state_t;

  function automatic logic mlt_hits(input mlt_rf_hdr_t h, input logic [15:0] cl,
                                    input logic [7:0] ep);
    return !h.agg && (h.cluster == cl) && (h.dst_ep == ep);
  endfunction : mlt_hits

  function automatic mlt_rf_hdr_t mlt_hdr(input logic [63:0] a, input logic [15:0] cl,
                                          input logic [7:0] ep);
    return '{agg: 1'b0, addr: a, cluster: cl, src_ep: ep, dst_ep: ep};
  endfunction : mlt_hdr

endpackage : mlt_pkg

// File: mlt_service.sv
// Chosen here: the register offsets and the strobed register port.
`timescale 1ns/1ps
// Behaviour
// RULE1 - Aggregate argument equal to stored destination: destination becomes broadcaster
// RULE2 - Argument 0xFFFE never changes the destination; only routes refresh
// RULE3 - Destination changed in API mode: emit 0x8E frame to host
// RULE4 - Every aggregate broadcast records a route to its sender
// RULE5 - Aggregate command from host broadcasts to all other nodes
// RULE6 - Transparent mode sends unicast to the stored destination
// RULE7 - Data on cluster 0x12, endpoint 0xE8 echoes back to sender
// RULE8 - Transparent serial characters go to destination with cluster setting
// RULE9 - Host asks loopback with 0x11 frame, cluster 0x12, endpoints 0xE8
// RULE10 - Link-test request targets cluster 0x0014, endpoint 0xE6
// RULE11 - Request payload: 8-byte target, 2-byte size, 2-byte count
// RULE12 - Count must be 1 to 4000, else invalid-parameter result
// RULE13 - Requested size stays within the reported maximum payload
// RULE14 - After all test packets, result goes to requester cluster 0x0094
// RULE15 - Requester shows the result to its host as a 0x91 frame; the code does so only in API mode (api_r set)
// RULE16 - Result layout: address, four 2-byte fields, five 1-byte fields
// RULE17 - Result code 0x00 on success, 0x03 on invalid parameter
// RULE18 - Retries total all MAC retries; retry limit field reports setting
// RULE19 - Strongest, weakest and average signal level each reported
// RULE20 - Consumer ignores fields on error, signal fields with no acks
// RULE21 - Test packets go to named target; result goes to requester
// RULE22 - Multi-byte fields travel most significant byte first
module mlt_service
  import mlt_pkg::*;
#(
  parameter int          ECHO_DEPTH    = 256,
  parameter int          ROUTES        = 8,
  parameter logic [63:0] SERIAL_NUMBER = 64'h0000_0000_0000_0001  // Arbitrary value
) (
  input  wire logic         CLK,
  input  wire logic         ARST_N,
  input  wire logic [7:0]   REG_ADDR,
  input  wire logic [31:0]  REG_WDATA,
  input  wire logic         REG_WR,
  input  wire logic         REG_RD,
  output logic      [31:0]  REG_RDATA,
  input  wire logic         CMD_MODE_ACTIVE,
  input  wire logic         SER_RX_VALID,
  input  wire logic [7:0]   SER_RX_DATA,
  input  wire logic         RF_RX_START,
  input  wire mlt_rf_hdr_t  RF_RX_HDR,
  input  wire logic         RF_RX_VALID,
  input  wire logic [7:0]   RF_RX_DATA,
  input  wire logic         RF_RX_LAST,
  input  wire logic         RF_TX_DONE,
  input  wire mlt_tx_stat_t RF_TX_STAT,
  output logic              RF_TX_START,
  output mlt_rf_hdr_t       RF_TX_HDR,
  output logic              RF_TX_VALID,
  output logic      [7:0]   RF_TX_DATA,
  output logic              RF_TX_LAST,
  output logic              HOST_TX_VALID,
  output logic      [7:0]   HOST_TX_DATA,
  output logic              HOST_TX_LAST
);

  localparam int EW = $clog2(ECHO_DEPTH);
  localparam int RW = $clog2(ROUTES);

  // ****************************************
  // State
  // ****************************************
  mlt_state_t   state_r;
  logic         api_r;
  logic [15:0]  cluster_r;
  logic [63:0]  dest_r;
  logic [63:0]  agg_arg_r;
  logic         agg_req_r;
  logic [7:0]   retry_lim_r;
  logic [RW-1:0] route_idx_r;
  mlt_rf_hdr_t  rx_hdr_r;
  logic [167:0] rbuf_r;
  logic [15:0]  rcnt_r;
  logic [175:0] obuf_r;
  logic [15:0]  em_len_r;
  logic [15:0]  em_idx_r;
  logic [1:0]   em_src_r;
  logic         em_host_r;
  logic         em_wait_r;
  logic [63:0]  tgt_r;
  logic [63:0]  req_r;
  logic [15:0]  tsize_r;
  logic [15:0]  titer_r;
  logic [15:0]  sent_r;
  logic [15:0]  ack_r;
  logic [15:0]  rtry_r;
  logic [19:0]  rsum_r;
  logic [7:0]   strong_r;
  logic [7:0]   weak_r;
  logic [7:0]   tres_r;
  logic         div_go_r;
  logic         rt_we_r;
  logic [RW-1:0] rt_wp_r;
  logic [63:0]  rt_wd_r;
  logic [7:0]   rt_cnt_r;
  logic [7:0]   echo_rd;
  logic [63:0]  rt_rd;
  logic         div_done;
  logic [19:0]  avg_q;
  logic [31:0]  ctrl_rd;

  // ****************************************
  // Decode
  // ****************************************
  wire logic [167:0] rbuf_nxt = {rbuf_r[159:0], RF_RX_DATA};
  wire logic [15:0]  rx_len   = 16'(rcnt_r + 16'h1);
  wire logic         disp     = (state_r == S_RX) && RF_RX_VALID && RF_RX_LAST;
  wire logic [63:0]  agg_arg  = rbuf_nxt[63:0];
  wire logic         agg_move = rx_hdr_r.agg && (agg_arg != AGG_KEEP) && (dest_r == agg_arg);
  wire logic         is_loop  = mlt_hits(rx_hdr_r, CL_LOOPBACK, EP_DATA);
  wire logic         is_treq  = mlt_hits(rx_hdr_r, CL_TEST_REQ, EP_TEST) && (rx_len == LEN_TREQ);
  wire logic         is_tres  = mlt_hits(rx_hdr_r, CL_TEST_RES, EP_TEST) && (rx_len == LEN_TRES);
  wire logic [15:0]  req_iter = rbuf_nxt[15:0];
  wire logic         iter_bad = (req_iter == 16'h0) || (req_iter > MAX_ITER);
  wire logic         ser_go   = SER_RX_VALID && !api_r && !CMD_MODE_ACTIVE;
  wire logic         em_end   = em_idx_r == 16'(em_len_r - 16'h1);
  wire logic         last_pkt = sent_r == 16'(titer_r - 16'h1);
  wire logic [7:0]   byte_now = (em_src_r == SRC_ECHO) ? echo_rd :
                                (em_src_r == SRC_PAT)  ? em_idx_r[7:0] : obuf_r[175:168];
  wire logic [EW-1:0] echo_ra = (state_r == S_EMIT) ? EW'(em_idx_r + 16'h1) : '0;
  wire logic         echo_we  = (state_r == S_RX) && RF_RX_VALID && is_loop;
  wire logic [7:0]   avg_w    = (ack_r == 16'h0) ? 8'h00 : avg_q[7:0];
  // Strongest level is the smallest magnitude of -dBm
  wire logic [167:0] res_pay  = {tgt_r, tsize_r, titer_r, ack_r,  // [RULE16] [RULE22]
                                 rtry_r, tres_r, retry_lim_r,  // [RULE18]
                                 strong_r, weak_r, avg_w};  // [RULE19]

  always_comb begin
    ctrl_rd                         = '0;
    ctrl_rd[CTRL_API_BIT]           = api_r;
    ctrl_rd[CTRL_CL_LSB +: 16]      = cluster_r;
  end

  wire logic [31:0] rd_mux =
    (REG_ADDR == REG_CTRL)      ? ctrl_rd :
    (REG_ADDR == REG_DEST_HI)   ? dest_r[63:32] :
    (REG_ADDR == REG_DEST_LO)   ? dest_r[31:0] :
    (REG_ADDR == REG_SER_HI)    ? SERIAL_NUMBER[63:32] :
    (REG_ADDR == REG_SER_LO)    ? SERIAL_NUMBER[31:0] :
    (REG_ADDR == REG_AGG_HI)    ? agg_arg_r[63:32] :
    (REG_ADDR == REG_AGG_LO)    ? agg_arg_r[31:0] :
    (REG_ADDR == REG_RETRY)     ? {24'h0, retry_lim_r} :
    (REG_ADDR == REG_STATUS)    ? {16'h0, rt_cnt_r, 2'h0, agg_req_r, state_r} :
    (REG_ADDR == REG_ROUTE_IDX) ? 32'(route_idx_r) :
    (REG_ADDR == REG_ROUTE_HI)  ? rt_rd[63:32] :
    (REG_ADDR == REG_ROUTE_LO)  ? rt_rd[31:0] : 32'h0;

  // ****************************************
  // Echo buffer, route table, averager
  // ****************************************
  mlt_mem #(.W(8), .D(ECHO_DEPTH)) u_echo (
    .CLK(CLK), .ARST_N(ARST_N), .WE(echo_we), .WA(rcnt_r[EW-1:0]),
    .WD(RF_RX_DATA), .RA(echo_ra), .RD(echo_rd)
  );

  mlt_mem #(.W(64), .D(ROUTES)) u_routes (
    .CLK(CLK), .ARST_N(ARST_N), .WE(rt_we_r), .WA(rt_wp_r),
    .WD(rt_wd_r), .RA(route_idx_r), .RD(rt_rd)
  );

  mlt_avg_div #(.NW(20), .DW(16)) u_avg (
    .CLK(CLK), .ARST_N(ARST_N), .START(div_go_r), .NUM(rsum_r),
    .DEN(ack_r), .DONE(div_done), .QUO(avg_q)
  );

  // ****************************************
  // Register port
  // ****************************************
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      api_r       <= 1'b0;
      cluster_r   <= RST_CLUSTER;
      dest_r      <= RST_DEST;
      agg_arg_r   <= '0;
      retry_lim_r <= RST_RETRY;
      route_idx_r <= '0;
      REG_RDATA   <= '0;
    end else begin
      REG_RDATA <= REG_RD ? rd_mux : 32'h0;
      if (disp && agg_move) begin
        dest_r <= rx_hdr_r.addr;  // [RULE1] [RULE2]
      end else if (REG_WR && REG_ADDR == REG_DEST_HI) begin
        dest_r[63:32] <= REG_WDATA;
      end else if (REG_WR && REG_ADDR == REG_DEST_LO) begin
        dest_r[31:0] <= REG_WDATA;
      end
      if (REG_WR) begin
        unique case (REG_ADDR)
          REG_CTRL: begin
            api_r     <= REG_WDATA[CTRL_API_BIT];
            cluster_r <= REG_WDATA[CTRL_CL_LSB +: 16];
          end
          REG_AGG_HI:    agg_arg_r[63:32] <= REG_WDATA;
          REG_AGG_LO:    agg_arg_r[31:0]  <= REG_WDATA;
          REG_RETRY:     retry_lim_r      <= REG_WDATA[7:0];
          REG_ROUTE_IDX: route_idx_r      <= REG_WDATA[RW-1:0];
          default: ;
        endcase
      end
    end
  end

  // ****************************************
  // Route learning
  // ****************************************
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rt_we_r  <= 1'b0;
      rt_wp_r  <= '0;
      rt_wd_r  <= '0;
      rt_cnt_r <= '0;
    end else begin
      rt_we_r <= disp && rx_hdr_r.agg;  // [RULE4]
      rt_wd_r <= rx_hdr_r.addr;
      if (rt_we_r) begin
        rt_wp_r  <= RW'(rt_wp_r + 1'b1);
        rt_cnt_r <= (rt_cnt_r == 8'hff) ? rt_cnt_r : 8'(rt_cnt_r + 8'h1);
      end
    end
  end

  // ****************************************
  // Sequencer
  // ****************************************
  task automatic launch(input logic host, input mlt_rf_hdr_t h, input logic [15:0] len,
                        input logic [1:0] src, input logic wt);
    RF_TX_START <= !host;
    RF_TX_HDR   <= h;
    em_host_r   <= host;
    em_len_r    <= len;
    em_idx_r    <= 16'h0;
    em_src_r    <= src;
    em_wait_r   <= wt;
    state_r     <= (len == 16'h0) ? (wt ? S_WAIT : S_IDLE) : S_EMIT;
  endtask : launch

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      state_r <= S_IDLE;
      agg_req_r <= 1'b0;
      {rx_hdr_r, rbuf_r, rcnt_r, obuf_r} <= '0;
      {em_len_r, em_idx_r, em_src_r, em_host_r, em_wait_r} <= '0;
      {tgt_r, req_r, tsize_r, titer_r, sent_r, ack_r, rtry_r, rsum_r} <= '0;
      {strong_r, weak_r, tres_r, div_go_r} <= '0;
      {RF_TX_START, RF_TX_HDR, RF_TX_VALID, RF_TX_DATA, RF_TX_LAST} <= '0;
      {HOST_TX_VALID, HOST_TX_DATA, HOST_TX_LAST} <= '0;
    end else begin
      {RF_TX_START, RF_TX_VALID, RF_TX_LAST, HOST_TX_VALID, HOST_TX_LAST} <= '0;
      div_go_r <= 1'b0;
      unique case (state_r)
        S_IDLE: begin
          if (RF_RX_START) begin
            rx_hdr_r <= RF_RX_HDR;
            rcnt_r   <= 16'h0;
            state_r  <= S_RX;
          end else if (agg_req_r) begin
            agg_req_r <= 1'b0;
            obuf_r    <= {agg_arg_r, 112'h0};
            launch(1'b0, '{agg: 1'b1, addr: BCAST_ADDR, cluster: 16'h0, src_ep: 8'h0,
                   dst_ep: 8'h0}, LEN_AGG, SRC_BUF, 1'b0);  // [RULE5]
          end else if (ser_go) begin
            obuf_r <= {SER_RX_DATA, 168'h0};
            launch(1'b0, mlt_hdr(dest_r, cluster_r, EP_DATA), 16'h1, SRC_BUF,
                   1'b0);  // [RULE6] [RULE8]
          end
        end
        S_RX: begin
          if (RF_RX_VALID) begin
            rbuf_r <= rbuf_nxt;
            rcnt_r <= rx_len;
            state_r <= RF_RX_LAST ? S_IDLE : S_RX;
          end
          if (disp) begin
            if (rx_hdr_r.agg) begin
              if (agg_move && api_r) begin
                obuf_r <= {FT_AGG_UPDATE, rx_hdr_r.addr, agg_arg, 40'h0};
                launch(1'b1, rx_hdr_r, LEN_AGG_FRM, SRC_BUF, 1'b0);  // [RULE3]
              end
            end else if (is_loop) begin
              launch(1'b0, mlt_hdr(rx_hdr_r.addr, CL_LOOPBACK, EP_DATA), rx_len,
                     SRC_ECHO, 1'b0);  // [RULE7]
            end else if (is_treq) begin
              tgt_r    <= rbuf_nxt[95:32];
              tsize_r  <= rbuf_nxt[31:16];
              titer_r  <= req_iter;
              req_r    <= rx_hdr_r.addr;  // [RULE21]
              {sent_r, ack_r, rtry_r, rsum_r, weak_r} <= '0;
              strong_r <= 8'hff;
              if (iter_bad) begin
                tres_r   <= RES_BADPARAM;  // [RULE12] [RULE17]
                div_go_r <= 1'b1;
                state_r  <= S_DIV;
              end else begin
                tres_r <= RES_OK;  // [RULE17]
                launch(1'b0, mlt_hdr(rbuf_nxt[95:32], CL_TEST_PKT, EP_TEST),
                       rbuf_nxt[31:16], SRC_PAT, 1'b1);  // [RULE21]
              end
            end else if (is_tres && api_r) begin
              obuf_r <= {FT_EXPL_RX, rbuf_nxt};
              launch(1'b1, rx_hdr_r, LEN_RES_FRM, SRC_BUF, 1'b0);  // [RULE15]
            end
          end
        end
        S_EMIT: begin
          if (em_host_r) begin
            HOST_TX_VALID <= 1'b1;
            HOST_TX_DATA  <= byte_now;
            HOST_TX_LAST  <= em_end;
          end else begin
            RF_TX_VALID <= 1'b1;
            RF_TX_DATA  <= byte_now;
            RF_TX_LAST  <= em_end;
          end
          obuf_r   <= {obuf_r[167:0], 8'h00};  // [RULE22]
          em_idx_r <= 16'(em_idx_r + 16'h1);
          if (em_end) begin
            state_r <= em_wait_r ? S_WAIT : S_IDLE;
          end
        end
        S_WAIT: begin
          if (RF_TX_DONE) begin
            sent_r <= 16'(sent_r + 16'h1);
            rtry_r <= 16'(rtry_r + {12'h0, RF_TX_STAT.retries});  // [RULE18]
            if (RF_TX_STAT.ack) begin
              ack_r  <= 16'(ack_r + 16'h1);
              rsum_r <= 20'(rsum_r + {12'h0, RF_TX_STAT.rssi});
              if (RF_TX_STAT.rssi < strong_r) strong_r <= RF_TX_STAT.rssi;  // [RULE19]
              if (RF_TX_STAT.rssi > weak_r) weak_r <= RF_TX_STAT.rssi;  // [RULE19]
            end
            if (last_pkt) begin
              div_go_r <= 1'b1;
              state_r  <= S_DIV;
            end else begin
              launch(1'b0, mlt_hdr(tgt_r, CL_TEST_PKT, EP_TEST), tsize_r, SRC_PAT, 1'b1);
            end
          end
        end
        S_DIV: begin
          if (div_done) begin
            obuf_r <= {res_pay, 8'h00};
            launch(1'b0, mlt_hdr(req_r, CL_TEST_RES, EP_TEST), LEN_TRES, SRC_BUF,
                   1'b0);  // [RULE14]
          end
        end
      endcase
      // A write in the launch cycle still wins
      if (REG_WR && REG_ADDR == REG_AGG_LO) agg_req_r <= 1'b1;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!ARST_N);

  property p_agg_keep;
    disp && rx_hdr_r.agg && agg_arg == AGG_KEEP |=> $stable(dest_r);
  endproperty
  a_agg_keep: assert property (p_agg_keep) else $error("Keep argument moved dest"); // [RULE2]

  property p_agg_move;
    disp && agg_move |=> dest_r == $past(rx_hdr_r.addr);
  endproperty
  a_agg_move: assert property (p_agg_move) else $error("Dest not moved"); // [RULE1]

  property p_agg_frame;
    disp && agg_move && api_r |-> ##2 HOST_TX_VALID && HOST_TX_DATA == FT_AGG_UPDATE;
  endproperty
  a_agg_frame: assert property (p_agg_frame) else $error("No update frame"); // [RULE3]

  property p_route;
    disp && rx_hdr_r.agg |=> rt_we_r && rt_wd_r == $past(rx_hdr_r.addr);
  endproperty
  a_route: assert property (p_route) else $error("Route not learned"); // [RULE4]

  property p_bcast;
    state_r == S_IDLE && !RF_RX_START && agg_req_r |=> RF_TX_START && RF_TX_HDR.agg;
  endproperty
  a_bcast: assert property (p_bcast) else $error("No aggregate broadcast"); // [RULE5]

  property p_transp;
    state_r == S_IDLE && !RF_RX_START && !agg_req_r && ser_go
      |=> RF_TX_START && RF_TX_HDR.addr == $past(dest_r) && RF_TX_HDR.cluster == cluster_r
      ##1 RF_TX_VALID && RF_TX_DATA == $past(SER_RX_DATA, 2);
  endproperty
  a_transp: assert property (p_transp) else $error("Serial char not sent"); // [RULE6] [RULE8]

  property p_echo;
    disp && !rx_hdr_r.agg && is_loop |=> RF_TX_START && RF_TX_HDR.addr == $past(rx_hdr_r.addr);
  endproperty
  a_echo: assert property (p_echo) else $error("No echo"); // [RULE7]

  property p_badparam;
    disp && !rx_hdr_r.agg && !is_loop && is_treq && iter_bad |=> tres_r == RES_BADPARAM;
  endproperty
  a_badparam: assert property (p_badparam) else $error("Bad count accepted"); // [RULE12]

  property p_result;
    state_r == S_DIV && div_done
      |=> RF_TX_START && RF_TX_HDR.cluster == CL_TEST_RES && RF_TX_HDR.addr == req_r;
  endproperty
  a_result: assert property (p_result) else $error("Result misdirected"); // [RULE14]

  property p_strong;
    state_r == S_WAIT && RF_TX_DONE && RF_TX_STAT.ack |=> strong_r <= $past(RF_TX_STAT.rssi);
  endproperty
  a_strong: assert property (p_strong) else $error("Strongest not tracked"); // [RULE19]

endmodule : mlt_service

// File: tb.sv
`timescale 1ns/1ps
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin num_errors++; \
  $display("Error t=%0t got=%h exp=%h", $time, a, e); end end
module tb
  import mlt_pkg::*;
;
  logic CLK, ARST_N, REG_WR, REG_RD, CMD_MODE_ACTIVE, SER_RX_VALID, RF_RX_START, RF_RX_VALID;
  logic RF_RX_LAST, RF_TX_DONE, RF_TX_START, RF_TX_VALID, RF_TX_LAST, HOST_TX_VALID, HOST_TX_LAST;
  logic [7:0]   REG_ADDR, SER_RX_DATA, RF_RX_DATA, RF_TX_DATA, HOST_TX_DATA, txq[$], hq[$], pl[$];
  logic [31:0]  REG_WDATA, REG_RDATA, d;
  logic [63:0]  tpa;
  logic [167:0] er;
  mlt_rf_hdr_t  RF_RX_HDR, RF_TX_HDR, txh;
  mlt_tx_stat_t RF_TX_STAT;
  int           num_errors, n_compared, nl, hl;
  logic [39:0]  rows [6] = '{{REG_CTRL, 32'h1100}, {REG_DEST_HI, 32'h0}, {REG_DEST_LO, 32'hffff},
                           {REG_RETRY, 32'h0a}, {REG_STATUS, 32'h1}, {8'hfc, 32'h0}};
  mlt_service u_mlt_service (.*);
  mlt_peer    u_mlt_peer (.*);
  // ****
  // Clock, monitor and tasks
  // ****
  initial begin
    CLK = 1'b0;
    forever #12.5 CLK = ~CLK;
  end
  always @(posedge CLK) begin
    if (RF_TX_START) txh <= RF_TX_HDR;
    if (RF_TX_START && RF_TX_HDR.cluster == CL_TEST_PKT) tpa <= RF_TX_HDR.addr;
    if (RF_TX_VALID) txq.push_back(RF_TX_DATA);
    if (RF_TX_LAST) nl++;
    if (HOST_TX_VALID) hq.push_back(HOST_TX_DATA);
    if (HOST_TX_LAST) hl++;
  end
  task automatic complete_run();
    if (num_errors == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : complete_run
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge CLK);
    REG_ADDR  <= a;
    REG_WDATA <= v;
    REG_WR    <= 1'b1;
    @(posedge CLK);
    REG_WR <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge CLK);
    REG_ADDR <= a;
    REG_RD   <= 1'b1;
    @(posedge CLK);
    REG_RD <= 1'b0;
    @(negedge CLK);
    d = REG_RDATA;
  endtask : rd
  task automatic load(input logic [167:0] v, input int n);
    pl = {};
    for (int i = n - 1; i >= 0; i--) pl.push_back(v[8*i+:8]);
  endtask : load
  // Sender header only; payload comes from pl, MSB first
  task automatic rx(input logic [63:0] a, input logic [15:0] c, input logic [7:0] e,
                    input logic g);
    @(posedge CLK);
    RF_RX_START <= 1'b1;
    RF_RX_HDR   <= '{g, a, c, e, e};
    foreach (pl[i]) begin
      @(posedge CLK);
      RF_RX_START <= 1'b0;
      RF_RX_VALID <= 1'b1;
      RF_RX_DATA  <= pl[i];
      RF_RX_LAST  <= (i == pl.size() - 1);
    end
    @(posedge CLK);
    RF_RX_VALID <= 1'b0;
    RF_RX_LAST  <= 1'b0;
  endtask : rx
  task automatic wt(input int n, input int h);
    for (int k = 0; k < 3000 && (nl < n || hl < h); k++) @(negedge CLK);
    if (nl < n || hl < h) begin
      num_errors++;
      complete_run();
    end else repeat (4) @(posedge CLK);
  endtask : wt
  // ****
  // Sequence
  // ****
  initial begin
    {ARST_N, REG_WR, REG_RD, CMD_MODE_ACTIVE, SER_RX_VALID, RF_RX_START, RF_RX_VALID} = '0;
    {RF_RX_LAST, REG_ADDR, REG_WDATA, SER_RX_DATA, RF_RX_DATA, RF_RX_HDR} = '0;
    repeat (4) @(posedge CLK);
    ARST_N <= 1'b1;
    foreach (rows[i]) begin
      rd(rows[i][39:32]);
      `CHK(d, rows[i][31:0])
    end
    load(168'ha53c, 2);
    rx(64'h77, CL_LOOPBACK, EP_DATA, 1'b0);
    wt(1, 0);
    `CHK({txh.addr, txq[0], txq[1]}, {64'h77, 16'ha53c})
    wr(REG_CTRL, 32'h1101);
    load(168'hffff, 8);
    rx(64'h1234_5678_9abc_def0, 16'h0, 8'h0, 1'b1);
    wt(1, 1);
    `CHK(hq[0], FT_AGG_UPDATE)
    rd(REG_DEST_LO);
    `CHK(d, 32'h9abc_def0)
    rd(REG_ROUTE_LO);
    `CHK(d, 32'h9abc_def0)
    wr(REG_DEST_HI, 32'h0);
    wr(REG_DEST_LO, 32'hfffe);
    load(168'(AGG_KEEP), 8);
    rx(64'h55, 16'h0, 8'h0, 1'b1);
    repeat (30) @(posedge CLK);
    rd(REG_DEST_LO);
    `CHK({hl, d}, {32'h1, 32'hfffe})
    // Two packets: retries 2+2, levels 0x50 and 0x54
    load({64'habc, 32'h0003_0002}, 12);
    rx(64'h4242, CL_TEST_REQ, EP_TEST, 1'b0);
    wt(4, 1);
    er = {64'habc, 16'h3, 16'h2, 16'h2, 16'h4, 8'h0, RST_RETRY, 8'h50, 8'h54, 8'h52};
    for (int i = 0; i < 21; i++) begin
      `CHK(txq[txq.size() - 21 + i], er[8*(20-i)+:8])
    end
    `CHK({txh.cluster, txh.dst_ep}, {CL_TEST_RES, EP_TEST})
    `CHK({txh.addr, tpa}, {64'h4242, 64'habc})
    for (int k = 0; k < 2; k++) begin
      load({64'habc, 16'h3, k ? 16'h0fa1 : 16'h0}, 12);
      rx(64'h4242, CL_TEST_REQ, EP_TEST, 1'b0);
      wt(5 + k, 1);
      `CHK(txq[txq.size() - 5], RES_BADPARAM)
    end
    load(er, 21);
    rx(64'h4242, CL_TEST_RES, EP_TEST, 1'b0);
    wt(6, 2);
    `CHK(hq[hq.size() - 22], FT_EXPL_RX)
    wr(REG_CTRL, 32'h1200);
    @(posedge CLK);
    CMD_MODE_ACTIVE <= 1'b1;
    SER_RX_VALID    <= 1'b1;
    SER_RX_DATA     <= 8'h3c;
    @(posedge CLK);
    CMD_MODE_ACTIVE <= 1'b0;
    SER_RX_DATA     <= 8'hc3;
    @(posedge CLK);
    SER_RX_VALID <= 1'b0;
    wt(7, 2);
    `CHK({txh.addr, txh.cluster, txq[txq.size() - 1]}, {64'hfffe, CL_LOOPBACK, 8'hc3})
    wr(REG_AGG_HI, 32'h0);
    wr(REG_AGG_LO, 32'hffff);
    wt(8, 2);
    `CHK({txh.agg, txh.addr}, {1'b1, BCAST_ADDR})
    ARST_N <= 1'b0;
    @(posedge CLK);
    ARST_N <= 1'b1;
    rd(REG_DEST_LO);
    `CHK(d, RST_DEST[31:0])
    complete_run();
  end
endmodule : tb
